// ### inc/sacc_pkg.sv
// constants, types and helpers shared by the conversion control block
package sacc_pkg;

  // ==========================================================================
  // result format
  localparam int RES_BITS = 14;
  localparam int RES_STEPS = 16384;

  // ==========================================================================
  // timing
  localparam int CLK_MHZ = 250;
  localparam int CLK_HI_NS = 3000;
  localparam int CLK_LO_NS = 500;
  localparam int CONV_MAX_NS = 50000;
  localparam int START_MIN_NS = 150;
  localparam int HI_CYC = (CLK_HI_NS * CLK_MHZ) / 1000;
  localparam int LO_CYC = (CLK_LO_NS * CLK_MHZ) / 1000;
  localparam int CONV_MAX_CYC = (CONV_MAX_NS * CLK_MHZ) / 1000;
  localparam int START_MIN_CYC = (START_MIN_NS * CLK_MHZ + 999) / 1000;

  // ==========================================================================
  // result buffer
  localparam int FIFO_DEPTH = 8;

  // ==========================================================================
  // conversion sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RESET = 3'b001,
    ST_CONV = 3'b010,
    ST_HOLD = 3'b011,
    ST_DONE = 3'b100
  } sacc_state_t;

  // ==========================================================================
  // synchroniser filter: take the new level once stages two and three agree
  function automatic logic sacc_filt(input logic cur, input logic s2, input logic s3);
    return (s2 == s3) ? s2 : cur;
  endfunction : sacc_filt

endpackage : sacc_pkg

// ### hw/sacc_fifo.sv
// result word buffer with valid and ready on both sides
module sacc_fifo #(
  parameter int WIDTH = 15,
  parameter int DEPTH = 8
) (
  input wire logic clk_sys_in,
  input wire logic srst_in,
  input wire logic in_valid_in,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic in_ready_out,
  output logic out_valid_out,
  output logic [WIDTH-1:0] out_data_out,
  input wire logic out_ready_in
);
  import sacc_pkg::*;

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr_idx;
    logic [AW-1:0] rd_idx;
    logic [AW:0] count;
  } sacc_fifo_t;

  sacc_fifo_t q_ff;
  sacc_fifo_t nxt_q;
  logic do_wr;
  logic do_rd;

  // ==========================================================================
  // next state
  always_comb
  begin
    nxt_q = q_ff;
    do_wr = in_valid_in && (q_ff.count != (AW + 1)'(DEPTH));
    do_rd = out_ready_in && (q_ff.count != '0);
    if (do_wr)
    begin
      nxt_q.mem[q_ff.wr_idx] = in_data_in;
      nxt_q.wr_idx = (q_ff.wr_idx == AW'(DEPTH - 1)) ? '0 : q_ff.wr_idx + 1'b1;
    end
    if (do_rd)
    begin
      nxt_q.rd_idx = (q_ff.rd_idx == AW'(DEPTH - 1)) ? '0 : q_ff.rd_idx + 1'b1;
    end
    if (do_wr && !do_rd)
    begin
      nxt_q.count = q_ff.count + 1'b1;
    end
    else if (do_rd && !do_wr)
    begin
      nxt_q.count = q_ff.count - 1'b1;
    end
    if (srst_in)
    begin
      nxt_q = '0;
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    q_ff <= nxt_q;
  end

  assign in_ready_out = (q_ff.count != (AW + 1)'(DEPTH));
  assign out_valid_out = (q_ff.count != '0);
  assign out_data_out = q_ff.mem[q_ff.rd_idx];

endmodule : sacc_fifo

// ### hw/sacc_ctrl.sv
// successive-approximation conversion control with result link
// Overview of operation
// R1: while start is high the converter is held in reset, and a conversion begins when start falls.
// R2: the host drives start as a high pulse of at least 150 ns per conversion.
// R3: a conversion completes no later than 50 us after it begins; while the result buffer is full it waits in ST_HOLD, eoc high.
// R4: the result resolves 16384 steps, a 14-bit word.
// R5: the result sits on 14 parallel lines and stays put until the next conversion command.
// R6: unipolar ranges give straight binary and bipolar ranges offset binary.
// R7: an extra inverted msb output gives two's complement for bipolar results.
// R8: coding sense is reversed, the most negative input giving all ones.
// R9: a non-return-to-zero serial output runs beside the parallel result.
// R10: each bit decision goes out serially as made, msb first, high for one and low for zero.
// R11: end of conversion is high during reset and conversion and low once it is complete.
// R12: the internal conversion clock is driven out as 3 us high pulses.
// R13: one bit is decided per internal clock period, msb first, and the word is loaded after the last.
// R14: a start during a conversion abandons it and restarts, leaving the held word untouched.
module sacc_ctrl #(
  parameter int W = sacc_pkg::RES_BITS,
  parameter int HI_CYC = sacc_pkg::HI_CYC,
  parameter int LO_CYC = sacc_pkg::LO_CYC,
  parameter int CONV_MAX_CYC = sacc_pkg::CONV_MAX_CYC,
  parameter int DEPTH = sacc_pkg::FIFO_DEPTH
) (
  input wire logic clk_sys_in,
  input wire logic srst_in,
  input wire logic start_in,
  input wire logic cmp_in,
  input wire logic bipolar_in,
  output logic [W-1:0] data_out,
  output logic msb_n_out,
  output logic ser_out,
  output logic eoc_out,
  output logic clk_out,
  output logic [W-1:0] trial_out,
  output logic bipolar_out,
  input wire logic link_clk_in,
  input wire logic link_ready_in,
  output logic link_valid_out,
  output logic [W-1:0] link_data_out,
  output logic link_bipolar_out
);
  import sacc_pkg::*;

  localparam int PER = HI_CYC + LO_CYC;
  localparam int PW = $clog2(PER + 1);
  localparam int IW = $clog2(W);
  localparam int CW = $clog2(CONV_MAX_CYC + 2);

  // ==========================================================================
  // state of the system clock domain
  typedef struct packed {
    sacc_state_t st;
    logic [2:0] start_s;
    logic start;
    logic [2:0] cmp_s;
    logic cmp;
    logic [2:0] bip_s;
    logic bip;
    logic mode;
    logic [PW-1:0] phase;
    logic [IW-1:0] bit_idx;
    logic [W-1:0] sar;
    logic [W-1:0] par;
    logic msbn;
    logic ser;
    logic eoc;
    logic clko;
    logic mode_out;
    logic req;
    logic [2:0] ack_s;
    logic ack;
    logic busy;
    logic [W:0] xfer;
  } sacc_sys_t;

  // ==========================================================================
  // state of the link clock domain
  typedef struct packed {
    logic [2:0] rst_s;
    logic rst;
    logic [2:0] req_s;
    logic req;
    logic ack;
    logic valid;
    logic [W-1:0] data;
    logic mode;
  } sacc_link_t;

  sacc_sys_t s_ff;
  sacc_sys_t nxt_s;
  sacc_link_t l_ff;
  sacc_link_t nxt_l;
  logic fin;
  logic push;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [W:0] fifo_out_data;

  // ==========================================================================
  // result buffer between the sequencer and the link hand-off
  sacc_fifo #(
    .WIDTH(W + 1),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clk_sys_in(clk_sys_in),
    .srst_in(srst_in),
    .in_valid_in(push),
    .in_data_in({s_ff.mode, ~s_ff.sar}),
    .in_ready_out(fifo_in_ready),
    .out_valid_out(fifo_out_valid),
    .out_data_out(fifo_out_data),
    .out_ready_in(!s_ff.busy)
  );

  // ==========================================================================
  // sequencer next state
  always_comb
  begin
    nxt_s = s_ff;
    fin = 1'b0;
    push = 1'b0;
    // pin inputs pass three stages; a pulse of the minimum width spans many cycles
    nxt_s.start_s = {s_ff.start_s[1:0], start_in};
    nxt_s.start = sacc_filt(s_ff.start, s_ff.start_s[1], s_ff.start_s[2]); // R2
    nxt_s.cmp_s = {s_ff.cmp_s[1:0], cmp_in};
    nxt_s.cmp = sacc_filt(s_ff.cmp, s_ff.cmp_s[1], s_ff.cmp_s[2]);
    nxt_s.bip_s = {s_ff.bip_s[1:0], bipolar_in};
    nxt_s.bip = sacc_filt(s_ff.bip, s_ff.bip_s[1], s_ff.bip_s[2]);
    nxt_s.ack_s = {s_ff.ack_s[1:0], l_ff.ack};
    nxt_s.ack = sacc_filt(s_ff.ack, s_ff.ack_s[1], s_ff.ack_s[2]);
    case (s_ff.st)
      ST_IDLE, ST_DONE:
      begin
        nxt_s.clko = 1'b0;
        if (s_ff.start)
        begin
          nxt_s.st = ST_RESET;
          nxt_s.eoc = 1'b1; // R11
        end
      end
      ST_RESET:
      begin
        nxt_s.eoc = 1'b1; // R11
        nxt_s.clko = 1'b0;
        if (!s_ff.start)
        begin
          // start released: first trial is the msb
          nxt_s.st = ST_CONV; // R1
          nxt_s.mode = s_ff.bip; // R6
          nxt_s.bit_idx = IW'(W - 1);
          nxt_s.phase = '0;
          nxt_s.sar = {1'b1, {(W - 1){1'b0}}}; // R4
          nxt_s.clko = 1'b1; // R12
        end
      end
      ST_CONV:
      begin
        if (s_ff.start)
        begin
          nxt_s.st = ST_RESET; // R14
          nxt_s.clko = 1'b0;
        end
        else
        begin
          if (s_ff.phase == PW'(HI_CYC - 1))
          begin
            // keep the trial bit when the input is at or above it
            nxt_s.sar[s_ff.bit_idx] = s_ff.cmp; // R13
            nxt_s.ser = s_ff.cmp; // R10
          end
          if (s_ff.phase == PW'(PER - 1))
          begin
            nxt_s.phase = '0;
            if (s_ff.bit_idx == '0)
            begin
              fin = 1'b1; // R13
            end
            else
            begin
              nxt_s.bit_idx = s_ff.bit_idx - 1'b1;
              nxt_s.sar[s_ff.bit_idx - 1'b1] = 1'b1;
            end
          end
          else
          begin
            nxt_s.phase = s_ff.phase + 1'b1;
          end
          nxt_s.clko = !fin && (nxt_s.phase < PW'(HI_CYC)); // R12
        end
      end
      ST_HOLD:
      begin
        nxt_s.clko = 1'b0;
        if (s_ff.start)
        begin
          nxt_s.st = ST_RESET; // R14
        end
        else
        begin
          fin = 1'b1;
        end
      end
      default:
      begin
        nxt_s.st = ST_IDLE;
      end
    endcase
    // word complete: wait for buffer room, then load and release eoc
    if (fin)
    begin
      if (fifo_in_ready)
      begin
        push = 1'b1;
        nxt_s.par = ~s_ff.sar; // R8 R5
        nxt_s.msbn = s_ff.sar[W-1]; // R7
        nxt_s.mode_out = s_ff.mode; // R6
        nxt_s.eoc = 1'b0; // R11
        nxt_s.st = ST_DONE;
      end
      else
      begin
        nxt_s.st = ST_HOLD;
      end
    end
    // hand buffered words to the link by toggle request
    if (fifo_out_valid && !s_ff.busy)
    begin
      nxt_s.xfer = fifo_out_data;
      nxt_s.busy = 1'b1;
      nxt_s.req = !s_ff.req;
    end
    else if (s_ff.busy && (s_ff.ack == s_ff.req))
    begin
      nxt_s.busy = 1'b0;
    end
    if (srst_in)
    begin
      nxt_s = '0;
      nxt_s.st = ST_IDLE;
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    s_ff <= nxt_s;
  end

  // ==========================================================================
  // link side next state
  always_comb
  begin
    nxt_l = l_ff;
    nxt_l.rst_s = {l_ff.rst_s[1:0], srst_in};
    nxt_l.rst = sacc_filt(l_ff.rst, l_ff.rst_s[1], l_ff.rst_s[2]);
    nxt_l.req_s = {l_ff.req_s[1:0], s_ff.req};
    nxt_l.req = sacc_filt(l_ff.req, l_ff.req_s[1], l_ff.req_s[2]);
    if (l_ff.rst)
    begin
      nxt_l.req = 1'b0;
      nxt_l.ack = 1'b0;
      nxt_l.valid = 1'b0;
      nxt_l.data = '0;
      nxt_l.mode = 1'b0;
    end
    else if (!l_ff.valid && (l_ff.req != l_ff.ack))
    begin
      // word is stable in the system domain until acknowledged
      nxt_l.data = s_ff.xfer[W-1:0];
      nxt_l.mode = s_ff.xfer[W];
      nxt_l.valid = 1'b1;
    end
    else if (l_ff.valid && link_ready_in)
    begin
      nxt_l.valid = 1'b0;
      nxt_l.ack = !l_ff.ack;
    end
  end

  always_ff @(posedge link_clk_in)
  begin
    l_ff <= nxt_l;
  end

  // ==========================================================================
  // outputs
  assign data_out = s_ff.par;
  assign msb_n_out = s_ff.msbn;
  assign ser_out = s_ff.ser; // R9
  assign eoc_out = s_ff.eoc;
  assign clk_out = s_ff.clko;
  assign trial_out = s_ff.sar;
  assign bipolar_out = s_ff.mode_out;
  assign link_valid_out = l_ff.valid;
  assign link_data_out = l_ff.data;
  assign link_bipolar_out = l_ff.mode;

  // ==========================================================================
  // checker helpers
  logic [CW-1:0] conv_cnt_ff;
  logic [PW-1:0] hi_len_ff;

  always_ff @(posedge clk_sys_in)
  begin
    if (srst_in || (s_ff.st != ST_CONV))
    begin
      conv_cnt_ff <= '0;
    end
    else if (conv_cnt_ff != '1)
    begin
      conv_cnt_ff <= conv_cnt_ff + 1'b1;
    end
    if (srst_in || !s_ff.clko)
    begin
      hi_len_ff <= '0;
    end
    else
    begin
      hi_len_ff <= hi_len_ff + 1'b1;
    end
  end

  // ==========================================================================
  // assertions
  sequence conv_begin;
    (s_ff.st == ST_RESET) && !s_ff.start;
  endsequence

  sequence bit_decide;
    (s_ff.st == ST_CONV) && !s_ff.start && (s_ff.phase == PW'(HI_CYC - 1));
  endsequence

  a_start_holds_reset: assert property (@(posedge clk_sys_in) disable iff (srst_in) // R1
    $rose(s_ff.start) |=> (s_ff.st == ST_RESET) && eoc_out)
    else $error("start high did not reset the converter");

  a_release_starts: assert property (@(posedge clk_sys_in) disable iff (srst_in) // R1
    conv_begin |=> (s_ff.st == ST_CONV) && clk_out && (trial_out == {1'b1, {(W - 1){1'b0}}}))
    else $error("start release did not begin a conversion");

  a_conv_time_bound: assert property (@(posedge clk_sys_in) disable iff (srst_in) // R3
    conv_cnt_ff <= CW'(CONV_MAX_CYC))
    else $error("conversion ran past its time limit");

  a_word_stable: assert property (@(posedge clk_sys_in) disable iff (srst_in) // R5
    !$stable(data_out) |-> $fell(eoc_out) && ($past(s_ff.st) != ST_RESET))
    else $error("parallel word changed outside a completion");

  a_msb_inverse: assert property (@(posedge clk_sys_in) disable iff (srst_in) // R7
    $fell(eoc_out) |-> (msb_n_out == !data_out[W-1]) && (bipolar_out == $past(s_ff.mode)))
    else $error("inverted msb does not match the word");

  a_reverse_code: assert property (@(posedge clk_sys_in) disable iff (srst_in) // R8
    $fell(eoc_out) |-> (data_out == ~trial_out))
    else $error("result not reverse coded");

  a_serial_bit: assert property (@(posedge clk_sys_in) disable iff (srst_in) // R10
    bit_decide |=> (ser_out == $past(s_ff.cmp)) && (trial_out[$past(s_ff.bit_idx)] == ser_out))
    else $error("serial output does not follow the decision");

  a_eoc_in_conv: assert property (@(posedge clk_sys_in) disable iff (srst_in) // R11
    conv_begin |=> eoc_out [*4])
    else $error("end of conversion low during conversion");

  a_clk_pulse_width: assert property (@(posedge clk_sys_in) disable iff (srst_in) // R12
    $fell(clk_out) && ($past(s_ff.st) == ST_CONV) && (s_ff.st != ST_RESET) |->
      ($past(hi_len_ff) == PW'(HI_CYC - 1)))
    else $error("clock pulse width wrong");

  a_last_bit_load: assert property (@(posedge clk_sys_in) disable iff (srst_in) // R13
    (s_ff.st == ST_CONV) && !s_ff.start && (s_ff.bit_idx == '0) && (s_ff.phase == PW'(PER - 1)) |=>
      (s_ff.st == ST_DONE) || (s_ff.st == ST_HOLD))
    else $error("word not completed after the last bit");

  a_abort_keeps_word: assert property (@(posedge clk_sys_in) disable iff (srst_in) // R14
    (s_ff.st == ST_CONV) && s_ff.start |=> (s_ff.st == ST_RESET) && $stable(data_out) && !clk_out)
    else $error("abort mishandled");

  a_link_hold: assert property (@(posedge link_clk_in) disable iff (l_ff.rst)
    link_valid_out && !link_ready_in |=> link_valid_out && $stable(link_data_out))
    else $error("link word dropped before acceptance");

endmodule : sacc_ctrl

// ### sim/sacc_host_model.sv
// host-side model: comparator on the trial code and sink for link words
module sacc_host_model #(
  parameter int W = 14
) (
  input wire logic link_clk_in,
  input wire logic [W-1:0] trial_in,
  input wire logic [W-1:0] vin_in,
  input wire logic stall_in,
  input wire logic link_valid_in,
  input wire logic [W-1:0] link_data_in,
  input wire logic link_bipolar_in,
  output logic cmp_out,
  output logic link_ready_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [W:0] rx_q[$];

  // ==========================================================================
  // analog side
  // ideal comparator, high when the held input is at or above the trial code
  assign cmp_out = (vin_in >= trial_in);

  // ==========================================================================
  // link sink
  initial link_ready_out = 1'b0;
  always @(posedge link_clk_in)
  begin
    if (link_valid_in === 1'b1 && link_ready_out)
      rx_q.push_back({link_bipolar_in, link_data_in});
    #2 link_ready_out = !stall_in;
  end
endmodule : sacc_host_model

// ### sim/testbench.sv
// self-checking bench for the conversion control block
`define CHK(got, exp) \
  begin \
    samples_checked++; \
    if ((got) !== (exp)) \
    begin \
      n_errors++; \
      $display("Error at %0t: got %h expected %h", $time, (got), (exp)); \
    end \
  end

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import sacc_pkg::*;
  localparam int W = RES_BITS;
  localparam int HI_C = 6;
  localparam int LO_C = 2;
  localparam int CONV_C = 120;
  localparam int TMO = 60000;

  logic clk_sys_in, srst_in, start_in, cmp_in, bipolar_in, link_clk_in, link_ready_in;
  logic [W-1:0] data_out, trial_out, link_data_out, vin;
  logic msb_n_out, ser_out, eoc_out, clk_out, bipolar_out, link_valid_out, link_bipolar_out, stall;
  logic [W:0] exp_q[$];
  logic [W-1:0] ser_sh;
  logic clk_d;
  int n_errors, samples_checked, cyc, hi_n, hi_bad, ser_n;

  sacc_ctrl #(.HI_CYC(HI_C), .LO_CYC(LO_C), .CONV_MAX_CYC(CONV_C)) sacc_ctrl_i (
    .clk_sys_in(clk_sys_in), .srst_in(srst_in), .start_in(start_in), .cmp_in(cmp_in),
    .bipolar_in(bipolar_in), .data_out(data_out), .msb_n_out(msb_n_out), .ser_out(ser_out),
    .eoc_out(eoc_out), .clk_out(clk_out), .trial_out(trial_out), .bipolar_out(bipolar_out),
    .link_clk_in(link_clk_in), .link_ready_in(link_ready_in), .link_valid_out(link_valid_out),
    .link_data_out(link_data_out), .link_bipolar_out(link_bipolar_out));

  sacc_host_model #(.W(W)) sacc_host_model_i (
    .link_clk_in(link_clk_in), .trial_in(trial_out), .vin_in(vin), .stall_in(stall),
    .link_valid_in(link_valid_out), .link_data_in(link_data_out),
    .link_bipolar_in(link_bipolar_out), .cmp_out(cmp_in), .link_ready_out(link_ready_in));

  // ==========================================================================
  // clocks, timeout and serial monitor
  initial
  begin
    clk_sys_in = 1'b0;
    forever #2 clk_sys_in = ~clk_sys_in;
  end
  initial
  begin
    link_clk_in = 1'b0;
    #0.7;
    forever #62.5 link_clk_in = ~link_clk_in;
  end
  always @(posedge clk_sys_in)
  begin
    cyc++;
    if (cyc == TMO)
    begin
      n_errors++;
      results();
    end
    #3;
    if (clk_out === 1'b1)
      hi_n++;
    if (clk_d === 1'b1 && clk_out === 1'b0)
    begin
      if (hi_n != HI_C)
        hi_bad++;
      ser_sh = {ser_sh[W-2:0], ser_out};
      ser_n++;
    end
    if (clk_out !== 1'b1)
      hi_n = 0;
    clk_d = clk_out;
  end

  // ==========================================================================
  // helpers
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask : tick

  task automatic pulse_start;
    start_in = 1'b1;
    tick(40);
    `CHK(eoc_out, 1'b1)
    `CHK(clk_out, 1'b0)
    start_in = 1'b0;
    hi_bad = 0;
    ser_n = 0;
  endtask : pulse_start

  task automatic wait_eoc(output int n);
    n = 0;
    while (eoc_out !== 1'b0 && n < 3000)
    begin
      tick(1);
      n++;
    end
  endtask : wait_eoc

  task automatic wait_drain;
    int n;
    n = 0;
    while (sacc_host_model_i.rx_q.size() < exp_q.size() && n < 20000)
    begin
      tick(1);
      n++;
    end
  endtask : wait_drain

  // ==========================================================================
  // scenarios
  task automatic t_convert(input logic [W-1:0] v, input logic bip);
    int n;
    vin = v;
    bipolar_in = bip;
    pulse_start();
    wait_eoc(n);
    `CHK(n <= CONV_C + 8, 1'b1)
    `CHK(data_out, ~v)
    `CHK(msb_n_out, v[W-1])
    `CHK(bipolar_out, bip)
    `CHK(ser_sh, v)
    `CHK(ser_n, W)
    `CHK(hi_bad, 0)
    tick(20);
    `CHK(data_out, ~v)
    exp_q.push_back({bip, ~v});
  endtask : t_convert

  task automatic t_abort(input logic [W-1:0] prev);
    int n;
    vin = 14'h0abc;
    pulse_start();
    tick(50);
    `CHK(eoc_out, 1'b1)
    vin = 14'h1234;
    bipolar_in = 1'b0;
    pulse_start();
    `CHK(data_out, ~prev)
    wait_eoc(n);
    `CHK(data_out, ~14'h1234)
    `CHK(ser_sh, 14'h1234)
    exp_q.push_back({1'b0, ~14'h1234});
  endtask : t_abort

  task automatic t_stall;
    int n;
    wait_drain();
    stall = 1'b1;
    for (int i = 0; i < 9; i++)
      t_convert(14'h0100 + 14'(i), i[0]);
    vin = 14'h3001;
    bipolar_in = 1'b1;
    pulse_start();
    tick(300);
    `CHK(eoc_out, 1'b1)
    `CHK(clk_out, 1'b0)
    stall = 1'b0;
    wait_eoc(n);
    `CHK(data_out, ~14'h3001)
    exp_q.push_back({1'b1, ~14'h3001});
  endtask : t_stall

  task automatic results;
    if (n_errors == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : results

  // ==========================================================================
  // main sequence
  initial
  begin
    logic [W-1:0] tv[5];
    tv = '{14'h0000, 14'h3fff, 14'h2000, 14'h1555, 14'h2aaa};
    srst_in = 1'b1;
    start_in = 1'b0;
    bipolar_in = 1'b0;
    stall = 1'b0;
    vin = '0;
    tick(160);
    srst_in = 1'b0;
    tick(1);
    `CHK(eoc_out, 1'b0)
    foreach (tv[i])
      t_convert(tv[i], i[0]);
    t_abort(tv[4]);
    t_stall();
    wait_drain();
    `CHK(sacc_host_model_i.rx_q.size(), exp_q.size())
    `CHK(link_valid_out, 1'b0)
    foreach (exp_q[i])
      if (i < sacc_host_model_i.rx_q.size())
        `CHK(sacc_host_model_i.rx_q[i], exp_q[i])
    results();
  end
endmodule : testbench
